// File: ee_defines.svh
// Constants for the two-wire serial EEPROM slave.
// Assumes a 100 MHz core clock and an external bus master.
// Contract
// - Answer only when the sent select bits equal the strapped select pins that the variant compares.
// - Smaller variant compares both select pins, four parts per bus.
// - Larger variant ignores the low select pin, two parts per bus.
// - Undriven select or lock pins read as low.
// - Data line is open-drain: pulled low or released, and also read.
// - Command and write bits are sampled on each clock rising edge.
// - Returned data changes only after a clock falling edge.
// - Lock pin low lets writes proceed normally.
// - Lock pin high refuses every write to the array.
// - Byte-wide storage, 512 or 1,024 locations by variant.
// - Accepted writes finish in an internal cycle of at most 5 ms.
`ifndef EE_DEFINES_SVH
`define EE_DEFINES_SVH

`define EE_DEV_TYPE      4'ha
`define EE_BYTE_BITS     4'h8
`define EE_PAGE_BITS     4
`define EE_WORDS_4K      512
`define EE_WORDS_8K      1024
`define EE_T_WR_MS       5
`define EE_CLK_MHZ       100
`define EE_T_WR_CYCLES   (`EE_T_WR_MS * 1000 * `EE_CLK_MHZ)

`endif

// File: ee_pkg.sv
// Types for the two-wire serial EEPROM slave.
// Assumes nothing beyond the compiler.
package ee_pkg;

  typedef enum logic [3:0] {
    EE_IDLE      = 4'h0,
    EE_DEV       = 4'h1,
    EE_DEV_ACK   = 4'h2,
    EE_WADDR     = 4'h3,
    EE_WADDR_ACK = 4'h4,
    EE_WDATA     = 4'h5,
    EE_WDATA_ACK = 4'h6,
    EE_RDATA     = 4'h7,
    EE_RACK      = 4'h8
  } ee_state_type;

endpackage

// File: ee_sync.sv
// Two-flip-flop synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to clk_in.
`timescale 1ns/1ps
module ee_sync #(
  parameter int WIDTH = 1
) (
  // Clock
  input  wire logic             clk_in,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds the second stage only
  always_ff @(posedge clk_in) begin
    meta_reg <= async_in;
    sync_reg <= meta_reg;
  end

  assign sync_out = sync_reg;

endmodule

// File: ee_mem.sv
// Byte-wide array with one write port and a registered read port.
// Assumes one access address shared by read and write.
`timescale 1ns/1ps
module ee_mem #(
  parameter int WORDS = 512,
  parameter int AW    = 9
) (
  // Clock
  input  wire logic          clk_in,
  // Access
  input  wire logic [AW-1:0] addr_in,
  input  wire logic          wr_en_in,
  input  wire logic [7:0]    wr_data_in,
  output logic      [7:0]    rd_data_out
);

  logic [7:0] mem_array [WORDS];
  logic [7:0] rd_reg;

  // Contents survive reset, as a nonvolatile array should
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_array[addr_in] <= wr_data_in;
    end
    rd_reg <= mem_array[addr_in];
  end

  assign rd_data_out = rd_reg;

endmodule

// File: ee_pin_select_eeprom.sv
// Two-wire serial EEPROM slave with strapped select pins and array lock.
// Assumes all pins are asynchronous; the bus pad resolves the open drain.
`timescale 1ns/1ps
`include "ee_defines.svh"
module ee_pin_select_eeprom #(
  parameter bit          VARIANT_8K = 1'b0,
  parameter int unsigned WR_CYCLES  = `EE_T_WR_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  // Serial bus
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_drive_out,
  output logic      sda_oe_out,
  // Strap pins, each with its pad drive sense
  input  wire logic chip_select_pin_lo_in,
  input  wire logic chip_select_pin_lo_driven_in,
  input  wire logic chip_select_pin_hi_in,
  input  wire logic chip_select_pin_hi_driven_in,
  input  wire logic array_lock_in,
  input  wire logic array_lock_driven_in,
  // Status
  output logic      write_busy_out
);

  localparam int WORDS = VARIANT_8K ? `EE_WORDS_8K : `EE_WORDS_4K;
  localparam int AW    = $clog2(WORDS);
  localparam int CW    = $clog2(WR_CYCLES + 1);
  localparam int PB    = `EE_PAGE_BITS;

  // Pin synchronisers
  logic [7:0] pins_sync;
  logic       scl_s;
  logic       sda_s;
  logic       cs_lo_s;
  logic       cs_hi_s;
  logic       lock_s;

  ee_sync #(
    .WIDTH (8)
  ) u_sync (
    .clk_in   (core_clk_in),
    .async_in ({scl_in, sda_in,
                chip_select_pin_lo_in, chip_select_pin_lo_driven_in,
                chip_select_pin_hi_in, chip_select_pin_hi_driven_in,
                array_lock_in, array_lock_driven_in}),
    .sync_out (pins_sync)
  );

  assign scl_s   = pins_sync[7];
  assign sda_s   = pins_sync[6];
  // Floating pins fall back to the pull-down level
  assign cs_lo_s = pins_sync[5] & pins_sync[4];
  assign cs_hi_s = pins_sync[3] & pins_sync[2];
  assign lock_s  = pins_sync[1] & pins_sync[0];

  // Device select decode
  function automatic logic dev_match(input logic [7:0] b, input logic hi, input logic lo);
    logic type_ok;
    logic hi_ok;
    logic lo_ok;
    type_ok = (b[7:4] == `EE_DEV_TYPE);
    hi_ok   = (b[3] == hi);
    // Low select bit is a page bit on the larger variant
    lo_ok   = VARIANT_8K ? 1'b1 : (b[2] == lo);
    return type_ok & hi_ok & lo_ok;
  endfunction

  // Bus edge detection
  logic scl_d_reg;
  logic scl_d_next;
  logic sda_d_reg;
  logic sda_d_next;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  always_comb begin
    scl_d_next = scl_s;
    sda_d_next = sda_s;
    // Idle high clock is what keeps start and stop readable
    scl_rise   = scl_s & ~scl_d_reg;
    scl_fall   = ~scl_s & scl_d_reg;
    bus_start  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    bus_stop   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_d_next;
      sda_d_reg <= sda_d_next;
    end
  end

  // Array
  logic       mem_we;
  logic [7:0] mem_rdata;
  logic [7:0] shift_reg;
  logic [AW-1:0] addr_reg;

  ee_mem #(
    .WORDS (WORDS),
    .AW    (AW)
  ) u_mem (
    .clk_in      (core_clk_in),
    .addr_in     (addr_reg),
    .wr_en_in    (mem_we),
    .wr_data_in  (shift_reg),
    .rd_data_out (mem_rdata)
  );

  // Protocol state
  ee_pkg::ee_state_type state_reg;
  ee_pkg::ee_state_type state_next;
  logic [3:0]    cnt_reg;
  logic [3:0]    cnt_next;
  logic [7:0]    shift_next;
  logic [AW-1:0] addr_next;
  logic          rw_reg;
  logic          rw_next;
  logic          wrote_reg;
  logic          wrote_next;
  logic          oe_reg;
  logic          oe_next;
  logic          busy_reg;
  logic          busy_next;
  logic [CW-1:0] busy_cnt_reg;
  logic [CW-1:0] busy_cnt_next;
  logic          sda_drive_reg;

  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    shift_next    = shift_reg;
    addr_next     = addr_reg;
    rw_next       = rw_reg;
    wrote_next    = wrote_reg;
    oe_next       = oe_reg;
    busy_next     = busy_reg;
    busy_cnt_next = busy_cnt_reg;
    mem_we        = 1'b0;

    // Self-timed programming cycle
    if (busy_reg) begin
      if (busy_cnt_reg == '0) begin
        busy_next = 1'b0;
      end else begin
        busy_cnt_next = busy_cnt_reg - 1'b1;
      end
    end

    if (bus_start) begin
      state_next = ee_pkg::EE_DEV;
      cnt_next   = 4'h0;
      oe_next    = 1'b0;
    end else if (bus_stop) begin
      state_next = ee_pkg::EE_IDLE;
      oe_next    = 1'b0;
      wrote_next = 1'b0;
      if (wrote_reg && !busy_reg) begin
        busy_next     = 1'b1;
        busy_cnt_next = CW'(WR_CYCLES - 1);
      end
    end else begin
      unique case (state_reg)
        ee_pkg::EE_IDLE: begin
          oe_next = 1'b0;
        end
        ee_pkg::EE_DEV,
        ee_pkg::EE_WADDR,
        ee_pkg::EE_WDATA: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next   = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == `EE_BYTE_BITS) begin
            cnt_next = 4'h0;
            if (state_reg == ee_pkg::EE_DEV) begin
              // Busy parts stay silent so the master can poll
              if (dev_match(shift_reg, cs_hi_s, cs_lo_s) && !busy_reg) begin
                oe_next    = 1'b1;
                rw_next    = shift_reg[0];
                state_next = ee_pkg::EE_DEV_ACK;
                if (VARIANT_8K) begin
                  addr_next[AW-1 -: 2] = shift_reg[2:1];
                end else begin
                  addr_next[AW-1] = shift_reg[1];
                end
              end else begin
                state_next = ee_pkg::EE_IDLE;
              end
            end else if (state_reg == ee_pkg::EE_WADDR) begin
              addr_next[7:0] = shift_reg;
              oe_next        = 1'b1;
              state_next     = ee_pkg::EE_WADDR_ACK;
            end else if (!lock_s) begin
              mem_we     = 1'b1;
              oe_next    = 1'b1;
              wrote_next = 1'b1;
              state_next = ee_pkg::EE_WDATA_ACK;
            end else begin
              // Locked array: refuse the byte with a not-acknowledge
              state_next = ee_pkg::EE_IDLE;
            end
          end
        end
        ee_pkg::EE_DEV_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              // Reads ignore the lock pin entirely
              shift_next = mem_rdata;
              oe_next    = ~mem_rdata[7];
              state_next = ee_pkg::EE_RDATA;
            end else begin
              oe_next    = 1'b0;
              state_next = ee_pkg::EE_WADDR;
            end
            cnt_next = 4'h0;
          end
        end
        ee_pkg::EE_WADDR_ACK: begin
          if (scl_fall) begin
            oe_next    = 1'b0;
            state_next = ee_pkg::EE_WDATA;
          end
        end
        ee_pkg::EE_WDATA_ACK: begin
          if (scl_fall) begin
            oe_next    = 1'b0;
            state_next = ee_pkg::EE_WDATA;
            // Page writes wrap inside the page, never into the next one
            addr_next[PB-1:0] = addr_reg[PB-1:0] + 1'b1;
          end
        end
        ee_pkg::EE_RDATA: begin
          if (scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (cnt_reg == `EE_BYTE_BITS) begin
              oe_next    = 1'b0;
              cnt_next   = 4'h0;
              state_next = ee_pkg::EE_RACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next    = ~shift_reg[6];
            end
          end
        end
        ee_pkg::EE_RACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              state_next = ee_pkg::EE_IDLE;
            end else begin
              addr_next = addr_reg + 1'b1;
            end
          end else if (scl_fall) begin
            shift_next = mem_rdata;
            oe_next    = ~mem_rdata[7];
            state_next = ee_pkg::EE_RDATA;
          end
        end
        default: begin
          state_next = ee_pkg::EE_IDLE;
          oe_next    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_reg     <= ee_pkg::EE_IDLE;
      cnt_reg       <= 4'h0;
      shift_reg     <= 8'h00;
      addr_reg      <= '0;
      rw_reg        <= 1'b0;
      wrote_reg     <= 1'b0;
      oe_reg        <= 1'b0;
      busy_reg      <= 1'b0;
      busy_cnt_reg  <= '0;
      sda_drive_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      shift_reg     <= shift_next;
      addr_reg      <= addr_next;
      rw_reg        <= rw_next;
      wrote_reg     <= wrote_next;
      oe_reg        <= oe_next;
      busy_reg      <= busy_next;
      busy_cnt_reg  <= busy_cnt_next;
      // Open drain: the driven level is always low
      sda_drive_reg <= 1'b0;
    end
  end

  assign sda_drive_out  = sda_drive_reg;
  assign sda_oe_out     = oe_reg;
  assign write_busy_out = busy_reg;

endmodule

// File: ee_psp_properties.sv
// Port-level checks for the pin-select EEPROM slave.
// Assumes binding into ee_pin_select_eeprom.
`timescale 1ns/1ps
module ee_psp_properties #(
  parameter int unsigned WR_CYCLES = 200
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Bus, lock and status
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_drive_out,
  input wire logic sda_oe_out,
  input wire logic array_lock_in,
  input wire logic array_lock_driven_in,
  input wire logic write_busy_out
);
  logic [31:0] busy_cnt_reg;
  logic [31:0] busy_cnt_next;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  // Counts the length of each programming cycle
  always_comb begin
    busy_cnt_next = write_busy_out ? busy_cnt_reg + 32'h1 : 32'h0;
  end
  always_ff @(posedge core_clk_in) begin
    busy_cnt_reg <= rst_in ? 32'h0 : busy_cnt_next;
  end
  chk_drive_low: assert property (!sda_drive_out)
    else $error("data pin driven high");
  chk_oe_clock_low: assert property ($changed(sda_oe_out) |-> !scl_in && !$past(scl_in))
    else $error("data output moved while clock high");
  chk_oe_holds: assert property ($changed(sda_oe_out) |=> $stable(sda_oe_out)[*4])
    else $error("data output did not hold");
  chk_busy_length: assert property ($fell(write_busy_out) |-> busy_cnt_reg == WR_CYCLES)
    else $error("programming cycle has wrong length");
  chk_busy_bound: assert property (busy_cnt_reg <= WR_CYCLES)
    else $error("programming cycle overran");
  chk_busy_nack: assert property (write_busy_out |-> !$rose(sda_oe_out))
    else $error("acknowledge while programming");
  chk_lock_no_prog: assert property ($rose(write_busy_out) |->
    !($past(array_lock_in, 2) && $past(array_lock_driven_in, 2)))
    else $error("programming while locked");
  chk_prog_after_stop: assert property ($rose(write_busy_out) |->
    scl_in && sda_in && $past(scl_in, 3))
    else $error("programming began without a stop");
  cov_prog: cover property ($rose(write_busy_out));
  cov_prog_end: cover property ($fell(write_busy_out));
  cov_ack: cover property ($rose(sda_oe_out));
endmodule

bind ee_pin_select_eeprom ee_psp_properties #(.WR_CYCLES(WR_CYCLES)) i_ee_psp_properties (
  .core_clk_in, .rst_in, .scl_in, .sda_in, .sda_drive_out, .sda_oe_out,
  .array_lock_in, .array_lock_driven_in, .write_busy_out);

// File: ee_i2c_master.sv
// Bus master model: clock low 50 ns, high 30 ns, 80 ns a bit.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
module ee_i2c_master (
  // Bus
  output logic      scl_out,
  output logic      sda_oe_out,
  input  wire logic sda_in
);
  logic [8:0] got;
  event       done;
  initial begin
    scl_out    = 1'b1; // Idle clock stays high
    sda_oe_out = 1'b0;
    got        = 9'h0;
  end
  // Data moves only while the clock is low; sampled late in the high phase
  task automatic clk_bit(input logic d, output logic r);
    #10 sda_oe_out = ~d;
    #40 scl_out = 1'b1;
    #25 r = sda_in;
    #5 scl_out = 1'b0;
  endtask
  task automatic start();
    if (!scl_out) begin
      #10 sda_oe_out = 1'b0;
      #40 scl_out = 1'b1;
    end
    #20 sda_oe_out = 1'b1;
    #30 scl_out = 1'b0;
  endtask
  task automatic stop();
    #10 sda_oe_out = 1'b1;
    #40 scl_out = 1'b1;
    #20 sda_oe_out = 1'b0;
    #40 scl_out = 1'b1; // Clock left high
  endtask
  // Eight bits then the ninth; got holds what the wire showed
  task automatic xfer(input logic [7:0] d, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], r);
      got[i] = r;
    end
    clk_bit(last, r);
    got[8] = r;
    -> done;
  endtask
endmodule

// File: ee_pin_select_eeprom_tb.sv
// Self-checking bench for the pin-select EEPROM slave.
// Assumes the master model ee_i2c_master and the bound checker.
`timescale 1ns/1ps
`include "ee_defines.svh"
module ee_pin_select_eeprom_tb;
  localparam int WRC = 200;
  logic        core_clk_in = 1'b0;
  logic        rst_in      = 1'b1;
  logic        scl;
  logic        m_oe;
  logic        d_oe;
  logic        d_drv;
  logic        busy;
  logic [5:0]  pins = 6'h2e; // {lock_d, lock, hi_d, hi, lo_d, lo}, all driven
  logic [7:0]  mdl [512];
  logic [8:0]  exp_q [$];
  logic [31:0] lfsr = 32'hc831;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  wire         sda = ~m_oe & (d_oe ? d_drv : 1'b1); // Pull-up wire

  always #5 core_clk_in = ~core_clk_in;

  ee_i2c_master i_ee_i2c_master (.scl_out(scl), .sda_oe_out(m_oe), .sda_in(sda));
  ee_pin_select_eeprom #(.VARIANT_8K(1'b0), .WR_CYCLES(WRC)) i_ee_pin_select_eeprom (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
    .sda_drive_out(d_drv), .sda_oe_out(d_oe),
    .chip_select_pin_lo_in(pins[0]), .chip_select_pin_lo_driven_in(pins[1]),
    .chip_select_pin_hi_in(pins[2]), .chip_select_pin_hi_driven_in(pins[3]),
    .array_lock_in(pins[4]), .array_lock_driven_in(pins[5]), .write_busy_out(busy));

  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp9(input logic [8:0] e, input logic [8:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic xb(input logic [7:0] d, input logic last, input logic [8:0] e);
    exp_q.push_back(e);
    i_ee_i2c_master.xfer(d, last);
  endtask
  task automatic wr(input logic [7:0] d, input logic nack);
    xb(d, 1'b1, {nack, d});
  endtask
  task automatic dsel(input logic [1:0] s, input logic p, input logic rw, input logic nack);
    i_ee_i2c_master.start();
    wr({`EE_DEV_TYPE, s, p, rw}, nack);
  endtask
  task automatic rd(input logic [8:0] a, input int n);
    dsel(2'b10, a[8], 1'b0, 1'b0);
    wr(a[7:0], 1'b0);
    dsel(2'b10, a[8], 1'b1, 1'b0);
    for (int i = 0; i < n; i++) begin
      xb(8'hff, i == n - 1, {i == n - 1, mdl[a + i[8:0]]});
    end
    i_ee_i2c_master.stop();
  endtask
  // Locked writes are refused at the first data byte, so call them with n = 1
  task automatic wt(input logic [8:0] a, input int n, input logic nack);
    dsel(2'b10, a[8], 1'b0, 1'b0);
    wr(a[7:0], 1'b0);
    for (int i = 0; i < n; i++) begin
      lfsr = step(lfsr);
      wr(lfsr[7:0], nack);
      if (!nack) mdl[{a[8:4], a[3:0] + i[3:0]}] = lfsr[7:0];
    end
    i_ee_i2c_master.stop();
  endtask
  task automatic settle();
    for (int i = 0; i < 2 * WRC && busy !== 1'b0; i++) @(negedge core_clk_in);
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(i_ee_i2c_master.done) begin
    cmp9(exp_q.pop_front(), i_ee_i2c_master.got);
  end
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (12) @(negedge core_clk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge core_clk_in);
    #3;
    wt(9'h13e, 3, 1'b0);
    dsel(2'b10, 1'b1, 1'b0, 1'b1);
    i_ee_i2c_master.stop();
    settle();
    cmp9(9'h000, {8'h00, busy});
    rd(9'h13e, 2);
    rd(9'h130, 1);
    @(negedge core_clk_in) pins[4] = 1'b1;
    wt(9'h130, 1, 1'b1);
    cmp9(9'h000, {8'h00, busy});
    rd(9'h130, 1);
    @(negedge core_clk_in) pins[5] = 1'b0;
    wt(9'h131, 2, 1'b0);
    cmp9(9'h001, {8'h00, busy});
    // Mid-run reset cuts the programming cycle; the array keeps its bytes
    @(negedge core_clk_in) rst_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    rst_in = 1'b0;
    cmp9(9'h000, {8'h00, busy});
    repeat (3) @(negedge core_clk_in);
    settle();
    rd(9'h130, 3);
    for (int k = 0; k < 8; k++) begin
      lfsr = step(lfsr);
      @(negedge core_clk_in) pins[3:0] = lfsr[3:0];
      for (int s = 0; s < 4; s++) begin
        dsel(s[1:0], 1'b0, 1'b0, s[1:0] != {&pins[3:2], &pins[1:0]});
        i_ee_i2c_master.stop();
      end
    end
    if (exp_q.size() != 0) num_errors++;
    tally_and_finish();
  end
endmodule
